// >>> tmc_map.vh
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
// Register byte offsets on the local register port.
`define TMC_ADDR_W 3
`define TMC_OFF_SC 3'h0
`define TMC_OFF_CNTH 3'h1
`define TMC_OFF_CNTL 3'h2
`define TMC_OFF_MODH 3'h3
`define TMC_OFF_MODL 3'h4
// Field positions in the status and control register.
`define TMC_SC_FLAG 7
`define TMC_SC_IE 6
`define TMC_SC_CPWM 5
`define TMC_SC_CLKS_HI 4
`define TMC_SC_CLKS_LO 3
`define TMC_SC_PS_HI 2
`define TMC_SC_PS_LO 0
// Clock source codes.
`define TMC_CLKS_NONE 2'h0
`define TMC_CLKS_BUS 2'h1
`define TMC_CLKS_FIXED 2'h2
`define TMC_CLKS_EXT 2'h3
// Reset values and the all-ones and one word constants.
`define TMC_RST_BYTE 8'h00
`define TMC_RST_WORD 16'h0000
`define TMC_RST_CLKS 2'h0
`define TMC_RST_PS 3'h0
`define TMC_ONES_WORD 16'hffff
`define TMC_ONE_WORD 16'h0001
// Prescaler divider width and read-latch state codes.
`define TMC_DIV_W 7
`define TMC_LAT_IDLE 3'h1
`define TMC_LAT_WLO 3'h2
`define TMC_LAT_WHI 3'h4
`endif

// >>> tmc_sync.v
`timescale 1ns/10ps
`include "tmc_map.vh"
// Three-stage synchronizer with a rising-edge pulse for a slow count source.
module tmc_sync
(
   input wire ref_clk,
   input wire resetn,
   input wire async_in,
   output wire rise_pulse
);
   // Synchronizer stages; the first is read only by the second.
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // Filtered level, updated only when stages two and three agree.
   reg level_q;

   // Shift the pin through the stages and track the agreed level.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
         begin
            level_q <= s3_q;
         end
      end
   end

   // A new high level counts as one source edge.
   assign rise_pulse = (s2_q == s3_q) & s3_q & ~level_q;
endmodule

// >>> tmc_prescale.v
`timescale 1ns/10ps
`include "tmc_map.vh"
// Power-of-two prescaler that thins a train of source ticks.
module tmc_prescale
(
   input wire ref_clk,
   input wire resetn,
   input wire clear,
   input wire tick_in,
   input wire [2:0] div_sel,
   output wire tick_out
);
   // Ripple of source ticks; its low bits pick the tap.
   reg [`TMC_DIV_W-1:0] div_q;

   // Mask of the divider bits that must all be one for a tap.
   function [`TMC_DIV_W-1:0] tmc_tap_mask;
      input [2:0] sel;
      begin
         tmc_tap_mask = ~({`TMC_DIV_W{1'b1}} << sel);
      end
   endfunction

   // Count source ticks; clearing keeps a stopped timer phase-aligned on restart.
   always @(posedge ref_clk)
   begin
      if (!resetn || clear)
      begin
         div_q <= {`TMC_DIV_W{1'b0}};
      end
      else if (tick_in)
      begin
         div_q <= div_q + {{(`TMC_DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // One output tick for every two-to-the-select input ticks.
   assign tick_out = tick_in & ((div_q & tmc_tap_mask(div_sel)) == tmc_tap_mask(div_sel));
endmodule

// >>> tmc_timer.v
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "tmc_map.vh"
// Counter core of the timer: source select, prescaler, modulo counter,
// overflow flag, coherent counter reads and coherent modulo writes.
module tmc_timer
(
   input wire ref_clk,
   input wire resetn,
   input wire [`TMC_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   input wire fixed_system_clock,
   input wire external_count_clock,
   input wire bdm_active,
   output wire overflow_irq,
   output wire [15:0] count_value,
   output wire count_down,
   output wire center_mode
);
   // Control fields of the status and control register.
   reg flag_q;
   reg flag_d;
   reg ie_q;
   reg center_q;
   reg [1:0] clk_sel_q;
   reg [2:0] ps_q;
   // Set by a read of the control register while the flag is set.
   reg arm_q;
   reg arm_d;
   // Counter and its direction (high means counting down).
   reg [15:0] cnt_q;
   reg [15:0] cnt_d;
   reg dir_q;
   reg dir_d;
   // Active modulo and the byte buffers that feed it.
   reg [15:0] mod_q;
   reg [7:0] mod_hi_buf_q;
   reg [7:0] mod_lo_buf_q;
   // Which modulo bytes have been written since the last commit.
   reg mod_hi_pend_q;
   reg mod_lo_pend_q;
   // Read-coherency latch state and held counter value.
   reg [2:0] lat_q;
   reg [2:0] lat_d;
   reg [15:0] hold_q;
   reg [15:0] hold_d;
   // Read data, valid in the cycle after the read strobe.
   reg [7:0] rdata_q;
   reg [7:0] rdata_d;
   // Decoded strobes.
   wire wr_sc;
   wire rd_sc;
   wire wr_cnt;
   wire rd_cnth;
   wire rd_cntl;
   wire wr_modh;
   wire wr_modl;
   // Count path.
   wire fixed_rise;
   wire ext_rise;
   reg src_tick;
   wire pre_tick;
   wire cnt_tick;
   wire [15:0] limit;
   reg ovf_evt;
   wire ovf_set;
   wire mod_pending;

   // Address decode for the register port.
   assign wr_sc = reg_wr & (reg_addr == `TMC_OFF_SC);
   assign rd_sc = reg_rd & (reg_addr == `TMC_OFF_SC);
   assign wr_cnt = reg_wr & ((reg_addr == `TMC_OFF_CNTH) | (reg_addr == `TMC_OFF_CNTL));
   assign rd_cnth = reg_rd & (reg_addr == `TMC_OFF_CNTH);
   assign rd_cntl = reg_rd & (reg_addr == `TMC_OFF_CNTL);
   assign wr_modh = reg_wr & (reg_addr == `TMC_OFF_MODH);
   assign wr_modl = reg_wr & (reg_addr == `TMC_OFF_MODL);

   // The fixed clock and the count pin come from outside this clock domain.
   tmc_sync u_fixed_sync
   (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(fixed_system_clock),
      .rise_pulse(fixed_rise)
   );

   tmc_sync u_ext_sync
   (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(external_count_clock),
      .rise_pulse(ext_rise)
   );

   // Pick the count source; the bus rate source ticks every cycle.
   // A pin source must stay below a quarter of the bus rate or edges are lost.
   always @*
   begin
      case (clk_sel_q)
         `TMC_CLKS_NONE: src_tick = 1'b0;
         `TMC_CLKS_BUS: src_tick = 1'b1;
         `TMC_CLKS_FIXED: src_tick = fixed_rise;
         `TMC_CLKS_EXT: src_tick = ext_rise;
         default: src_tick = 1'b0;
      endcase
   end

   // The prescaler sits after selection, so it divides whichever source is chosen.
   // Debug mode stops the source ticks, which also freezes the prescaler phase.
   tmc_prescale u_prescale
   (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clear(clk_sel_q == `TMC_CLKS_NONE),
      .tick_in(src_tick & ~bdm_active),
      .div_sel(ps_q),
      .tick_out(pre_tick)
   );

   // Counter enable, held off while debug mode is active.
   assign cnt_tick = pre_tick & ~bdm_active;

   // A zero or all-ones modulo lets the counter run over the full range.
   assign limit = (mod_q == `TMC_RST_WORD) ? `TMC_ONES_WORD : mod_q;

   // Next counter value and direction, plus the raw overflow event.
   // Leaving center mode drops the down direction at once, so a stopped source cannot strand it.
   always @*
   begin
      cnt_d = cnt_q;
      dir_d = dir_q & center_q;
      ovf_evt = 1'b0;
      if (wr_cnt)
      begin
         // Any value written to either byte restarts the count.
         cnt_d = `TMC_RST_WORD;
         dir_d = 1'b0;
      end
      else if (cnt_tick)
      begin
         if (!center_q)
         begin
            // Up mode; wrapping at all-ones also catches a modulo set below the count.
            dir_d = 1'b0;
            if ((cnt_q == limit) || (cnt_q == `TMC_ONES_WORD))
            begin
               cnt_d = `TMC_RST_WORD;
               ovf_evt = 1'b1;
            end
            else
            begin
               cnt_d = cnt_q + `TMC_ONE_WORD;
            end
         end
         else if (!dir_q)
         begin
            // Center mode rising half.
            if (cnt_q >= limit)
            begin
               dir_d = 1'b1;
               cnt_d = cnt_q - `TMC_ONE_WORD;
               ovf_evt = 1'b1;
            end
            else
            begin
               cnt_d = cnt_q + `TMC_ONE_WORD;
            end
         end
         else
         begin
            // Center mode falling half; turn upward at zero.
            if (cnt_q == `TMC_RST_WORD)
            begin
               dir_d = 1'b0;
               cnt_d = `TMC_ONE_WORD;
            end
            else
            begin
               cnt_d = cnt_q - `TMC_ONE_WORD;
            end
         end
      end
   end

   // A half-written modulo suppresses the flag until the second byte lands.
   assign mod_pending = mod_hi_pend_q | mod_lo_pend_q;
   assign ovf_set = ovf_evt & ~mod_pending;

   // Flag and its two-step clear; a new overflow wins and restarts the sequence.
   always @*
   begin
      flag_d = flag_q;
      arm_d = arm_q;
      if (rd_sc && flag_q)
      begin
         arm_d = 1'b1;
      end
      if (wr_sc)
      begin
         arm_d = 1'b0;
         // Writing a one leaves the flag as it is.
         if (arm_q && !reg_wdata[`TMC_SC_FLAG])
         begin
            flag_d = 1'b0;
         end
      end
      if (ovf_set)
      begin
         flag_d = 1'b1;
         arm_d = 1'b0;
      end
   end

   // Read-coherency latch: the first byte read captures both bytes.
   always @*
   begin
      lat_d = lat_q;
      hold_d = hold_q;
      if (wr_cnt || wr_sc)
      begin
         // Counter and control register writes restart the mechanism.
         lat_d = `TMC_LAT_IDLE;
      end
      else if (!bdm_active)
      begin
         case (lat_q)
            `TMC_LAT_IDLE:
            begin
               if (rd_cnth)
               begin
                  hold_d = cnt_q;
                  lat_d = `TMC_LAT_WLO;
               end
               else if (rd_cntl)
               begin
                  hold_d = cnt_q;
                  lat_d = `TMC_LAT_WHI;
               end
            end
            `TMC_LAT_WLO:
            begin
               if (rd_cntl)
               begin
                  lat_d = `TMC_LAT_IDLE;
               end
            end
            `TMC_LAT_WHI:
            begin
               if (rd_cnth)
               begin
                  lat_d = `TMC_LAT_IDLE;
               end
            end
            default:
            begin
               lat_d = `TMC_LAT_IDLE;
            end
         endcase
      end
      // In debug mode the latch keeps its state whatever is read.
   end

   // Read data mux; a held value answers while the latch is occupied.
   always @*
   begin
      rdata_d = `TMC_RST_BYTE;
      if (reg_rd)
      begin
         case (reg_addr)
            `TMC_OFF_SC: rdata_d = {flag_q, ie_q, center_q, clk_sel_q, ps_q};
            `TMC_OFF_CNTH: rdata_d = (lat_q == `TMC_LAT_IDLE) ? cnt_q[15:8] : hold_q[15:8];
            `TMC_OFF_CNTL: rdata_d = (lat_q == `TMC_LAT_IDLE) ? cnt_q[7:0] : hold_q[7:0];
            `TMC_OFF_MODH: rdata_d = mod_q[15:8];
            `TMC_OFF_MODL: rdata_d = mod_q[7:0];
            default: rdata_d = `TMC_RST_BYTE;
         endcase
      end
   end

   // Control register fields and flag state.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         flag_q <= 1'b0;
         arm_q <= 1'b0;
         ie_q <= 1'b0;
         center_q <= 1'b0;
         clk_sel_q <= `TMC_RST_CLKS;
         ps_q <= `TMC_RST_PS;
      end
      else
      begin
         flag_q <= flag_d;
         arm_q <= arm_d;
         if (wr_sc)
         begin
            ie_q <= reg_wdata[`TMC_SC_IE];
            center_q <= reg_wdata[`TMC_SC_CPWM];
            clk_sel_q <= reg_wdata[`TMC_SC_CLKS_HI:`TMC_SC_CLKS_LO];
            ps_q <= reg_wdata[`TMC_SC_PS_HI:`TMC_SC_PS_LO];
         end
      end
   end

   // Counter, direction, latch and read data.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         cnt_q <= `TMC_RST_WORD;
         dir_q <= 1'b0;
         lat_q <= `TMC_LAT_IDLE;
         hold_q <= `TMC_RST_WORD;
         rdata_q <= `TMC_RST_BYTE;
      end
      else
      begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
         lat_q <= lat_d;
         hold_q <= hold_d;
         rdata_q <= rdata_d;
      end
   end

   // Modulo bytes are buffered and committed together once both are written.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         mod_q <= `TMC_RST_WORD;
         mod_hi_buf_q <= `TMC_RST_BYTE;
         mod_lo_buf_q <= `TMC_RST_BYTE;
         mod_hi_pend_q <= 1'b0;
         mod_lo_pend_q <= 1'b0;
      end
      else if (wr_modh)
      begin
         if (mod_lo_pend_q)
         begin
            mod_q <= {reg_wdata, mod_lo_buf_q};
            mod_lo_pend_q <= 1'b0;
         end
         else
         begin
            mod_hi_buf_q <= reg_wdata;
            mod_hi_pend_q <= 1'b1;
         end
      end
      else if (wr_modl)
      begin
         if (mod_hi_pend_q)
         begin
            mod_q <= {mod_hi_buf_q, reg_wdata};
            mod_hi_pend_q <= 1'b0;
         end
         else
         begin
            mod_lo_buf_q <= reg_wdata;
            mod_lo_pend_q <= 1'b1;
         end
      end
   end

   // Interrupt request follows the flag while enabled.
   assign overflow_irq = flag_q & ie_q;
   assign reg_rdata = rdata_q;
   assign count_value = cnt_q;
   assign count_down = dir_q;
   assign center_mode = center_q;
endmodule

// >>> tmc_timer_monitor.sv
`timescale 1ns/10ps
`include "tmc_map.vh"
// Watches the timer ports for slips in counting, flag and read data.
module tmc_timer_monitor
(
   input wire ref_clk,
   input wire resetn,
   input wire [`TMC_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire fixed_system_clock,
   input wire external_count_clock,
   input wire bdm_active,
   input wire overflow_irq,
   input wire [15:0] count_value,
   input wire count_down,
   input wire center_mode
);
   default clocking dck @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // A write to either counter byte.
   sequence cnt_wr_s;
      reg_wr && (reg_addr == `TMC_OFF_CNTH || reg_addr == `TMC_OFF_CNTL);
   endsequence
   // A flag rise that no register write caused, so it must be an overflow.
   sequence ovf_rise_s;
      $rose(overflow_irq) && !$past(reg_wr);
   endsequence
   cnt_wr_zero_a: assert property (cnt_wr_s |=> count_value == `TMC_RST_WORD)
      else $error("counter write did not zero the counter");
   rst_values_a: assert property (disable iff (1'b0)
      !resetn |=> count_value == `TMC_RST_WORD && !overflow_irq && !center_mode && !count_down)
      else $error("reset values wrong");
   ovf_cause_a: assert property (ovf_rise_s |-> (center_mode ? count_down : count_value <= `TMC_ONE_WORD))
      else $error("overflow flag rose away from the turn point");
   up_step_a: assert property (!center_mode && !$past(center_mode) && $changed(count_value)
      && !$past(reg_wr) |-> count_value == $past(count_value) + `TMC_ONE_WORD || count_value == `TMC_RST_WORD)
      else $error("up counter stepped wrongly");
   center_step_a: assert property (center_mode && $past(center_mode) && $changed(count_value)
      && !$past(reg_wr) |-> count_value == (count_down ? $past(count_value) - `TMC_ONE_WORD
      : $past(count_value) + `TMC_ONE_WORD))
      else $error("center counter stepped against its direction");
   down_only_a: assert property (!center_mode && !$past(center_mode) |-> !count_down)
      else $error("down count outside center mode");
   irq_hold_a: assert property (overflow_irq && !reg_wr |=> overflow_irq)
      else $error("overflow request dropped without a write");
   bdm_freeze_a: assert property (bdm_active && !reg_wr |=> count_value == $past(count_value))
      else $error("counter moved in debug mode");
   rdata_idle_a: assert property (!reg_rd || reg_addr > `TMC_OFF_MODL |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   cover property (ovf_rise_s);
endmodule

bind tmc_timer tmc_timer_monitor mon (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .fixed_system_clock, .external_count_clock, .bdm_active, .overflow_irq, .count_value,
   .count_down, .center_mode);

// >>> tmc_timer_tb.sv
`timescale 1ns/10ps
`include "tmc_map.vh"
// Self-checking bench for the timer counter core.
module tmc_timer_tb;
   reg ref_clk = 1'b0;
   reg resetn = 1'b0;
   reg [2:0] reg_addr = 3'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg fixed_system_clock = 1'b0;
   reg external_count_clock = 1'b0;
   reg bdm_active = 1'b0;
   wire [7:0] reg_rdata;
   wire overflow_irq;
   wire [15:0] count_value;
   wire count_down;
   wire center_mode;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   int src_div = 0;
   int gap;
   logic [7:0] rv;
   logic [7:0] hi;
   logic [15:0] snap;
   logic [15:0] snap0;
   // Rows: write offset, write data, read offset, expected read byte.
   logic [7:0] rr [0:6][0:3] = '{'{8'h00, 8'h80, 8'h00, 8'h00}, '{8'h00, 8'h47, 8'h00, 8'h47},
      '{8'h03, 8'h12, 8'h03, 8'h00}, '{8'h04, 8'h34, 8'h03, 8'h12}, '{8'h05, 8'haa, 8'h05, 8'h00},
      '{8'h01, 8'h55, 8'h02, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h00}};
   // Rate rows: control byte and cycles between counts; 400 means the counter stands.
   logic [7:0] rate_sc [0:12] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
      8'h10, 8'h11, 8'h18, 8'h1b, 8'h00};
   int rate_gap [0:12] = '{1, 2, 4, 8, 16, 32, 64, 128, 8, 16, 12, 96, 400};

   tmc_timer uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fixed_system_clock(fixed_system_clock),
      .external_count_clock(external_count_clock), .bdm_active(bdm_active), .overflow_irq(overflow_irq),
      .count_value(count_value), .count_down(count_down), .center_mode(center_mode));

   always #10 ref_clk = ~ref_clk;

   // Slow pin sources: fixed has a period of 8 cycles, external 12, both under a quarter rate.
   always @(posedge ref_clk)
   begin
      src_div <= (src_div == 11) ? 0 : src_div + 1;
      if (src_div % 4 == 3)
         fixed_system_clock <= ~fixed_system_clock;
      if (src_div % 6 == 5)
         external_count_clock <= ~external_count_clock;
   end

   // Cuts a hang short; the whole run needs fewer cycles, most of them in the full-range wait.
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   task wr(input [2:0] a, input [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Snap holds the live count at the edge that takes the read.
   task rd(input [2:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      #1 snap = count_value;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask

   task wait_change(output int n);
      logic [15:0] old;
      old = count_value;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         #1 n++;
      end
      while (count_value === old && n < 400);
   endtask

   task wait_irq;
      int n;
      n = 0;
      while (overflow_irq !== 1'b1 && n < 1000)
      begin
         @(posedge ref_clk);
         #1 n++;
      end
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int a = 0; a < 8; a++)
      begin
         rd(a[2:0]);
         chk("reset byte", 16'h0000, {8'h00, rv});
      end
      for (int i = 0; i < 7; i++)
      begin
         wr(rr[i][0][2:0], rr[i][1]);
         rd(rr[i][2][2:0]);
         chk("register row", {8'h00, rr[i][3]}, {8'h00, rv});
      end
      $display("test registers done");
      // Interval between two counts is exact, whatever the prescaler phase.
      for (int i = 0; i < 13; i++)
      begin
         wr(`TMC_OFF_SC, rate_sc[i]); // No channel shares the count pin here
         wr(`TMC_OFF_CNTH, 8'h00);
         // Start from the settled zero so the first wait ends on a real count step.
         #1 wait_change(gap);
         wait_change(gap);
         chk("count interval", rate_gap[i][15:0], gap[15:0]);
      end
      $display("test rates done");
      wr(`TMC_OFF_MODH, 8'h00);
      wr(`TMC_OFF_MODL, 8'h05);
      wr(`TMC_OFF_SC, 8'h4f);
      wait_irq();
      chk("irq at wrap", 16'h0001, {15'h0000, overflow_irq});
      wr(`TMC_OFF_SC, 8'h4f);
      rd(`TMC_OFF_SC);
      chk("flag kept without read", 16'h00cf, {8'h00, rv});
      wr(`TMC_OFF_SC, 8'h4f);
      #1 chk("flag cleared", 16'h0000, {15'h0000, overflow_irq});
      wr(`TMC_OFF_SC, 8'h0f);
      repeat (800) @(posedge ref_clk);
      #1 chk("masked irq", 16'h0000, {15'h0000, overflow_irq});
      rd(`TMC_OFF_SC);
      chk("flag while masked", 16'h008f, {8'h00, rv});
      wr(`TMC_OFF_SC, 8'hcf);
      #1 chk("write one keeps flag", 16'h0001, {15'h0000, overflow_irq});
      rd(`TMC_OFF_SC);
      wr(`TMC_OFF_SC, 8'h4f);
      wr(`TMC_OFF_MODH, 8'h00);
      repeat (1600) @(posedge ref_clk);
      #1 chk("half modulo blocks flag", 16'h0000, {15'h0000, overflow_irq});
      wr(`TMC_OFF_MODL, 8'h05);
      wait_irq();
      chk("flag after modulo commit", 16'h0001, {15'h0000, overflow_irq});
      // An overflow between the arming read and the clearing write keeps the flag.
      rd(`TMC_OFF_SC);
      repeat (800) @(posedge ref_clk);
      wr(`TMC_OFF_SC, 8'h4f);
      #1 chk("flag kept after new overflow", 16'h0001, {15'h0000, overflow_irq});
      $display("test overflow done");
      rd(`TMC_OFF_SC);
      wr(`TMC_OFF_SC, 8'h00);
      wr(`TMC_OFF_CNTH, 8'h00); // Counter restarted before the modulo update
      wr(`TMC_OFF_MODL, 8'h04);
      wr(`TMC_OFF_MODH, 8'h00);
      wr(`TMC_OFF_SC, 8'h69);
      wait_irq();
      chk("center turn count", 16'h0003, count_value);
      chk("center turn down", 16'h0001, {15'h0000, count_down});
      chk("center mode", 16'h0001, {15'h0000, center_mode});
      gap = 0;
      while (count_down === 1'b1 && gap < 100)
      begin
         @(posedge ref_clk);
         #1 gap++;
      end
      chk("center bottom", 16'h0001, count_value);
      $display("test center done");
      wr(`TMC_OFF_MODH, 8'h00);
      wr(`TMC_OFF_MODL, 8'h00);
      wr(`TMC_OFF_SC, 8'h08);
      rd(`TMC_OFF_CNTH);
      snap0 = snap;
      hi = rv;
      repeat (50) @(posedge ref_clk);
      rd(`TMC_OFF_CNTL);
      chk("coherent pair", snap0, {hi, rv});
      rd(`TMC_OFF_CNTL);
      snap0 = snap;
      @(posedge ref_clk);
      bdm_active <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 snap = count_value;
      rd(`TMC_OFF_CNTH);
      repeat (30) @(posedge ref_clk);
      #1 chk("frozen count", snap, count_value);
      @(posedge ref_clk);
      bdm_active <= 1'b0;
      rd(`TMC_OFF_CNTH);
      chk("held high after debug", {8'h00, snap0[15:8]}, {8'h00, rv});
      for (int k = 0; k < 2; k++)
      begin
         rd(`TMC_OFF_CNTH);
         wr(k ? `TMC_OFF_CNTL : `TMC_OFF_SC, k ? 8'hff : 8'h08);
         rd(`TMC_OFF_CNTL);
         chk("latch released", {8'h00, snap[7:0]}, {8'h00, rv});
      end
      $display("test coherency done");
      // An all-ones modulo must let the count cover the whole range before it wraps.
      wr(`TMC_OFF_MODH, 8'hff);
      wr(`TMC_OFF_MODL, 8'hff);
      rd(`TMC_OFF_SC);
      wr(`TMC_OFF_SC, 8'h48);
      wr(`TMC_OFF_CNTH, 8'h00);
      repeat (65535) @(posedge ref_clk);
      #1 chk("count at top", 16'hffff, count_value);
      chk("no flag before wrap", 16'h0000, {15'h0000, overflow_irq});
      @(posedge ref_clk);
      #1 chk("wrap after full range", 16'h0000, count_value);
      chk("irq after full range", 16'h0001, {15'h0000, overflow_irq});
      $display("test full range done");
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(`TMC_OFF_MODL);
      chk("modulo after reset", 16'h0000, {8'h00, rv});
      chk("count after reset", 16'h0000, count_value);
      chk("irq after reset", 16'h0000, {15'h0000, overflow_irq});
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
